// ==== rpsm_pkg.sv ====
`default_nettype none
package rpsm_pkg;
   // register offsets
   localparam logic [7:0] ADDR_INT_CTRL   = 8'h01;
   localparam logic [7:0] ADDR_STATUS     = 8'h03;
   localparam logic [7:0] ADDR_TEMP       = 8'h20;
   localparam logic [7:0] ADDR_NV_CTRL    = 8'h30;
   localparam logic [7:0] ADDR_TURNOVER   = 8'h33;
   localparam logic [7:0] ADDR_RAM_FIRST  = 8'h38;
   localparam logic [7:0] ADDR_RAM_LAST   = 8'h3F;
   localparam int         RAM_DEPTH       = 8;
   // field positions
   localparam int         BIT_PWR_ON      = 5;
   localparam int         BIT_LV2         = 3;
   localparam int         BIT_LV1         = 2;
   localparam int         BIT_BUSY        = 7;
   localparam int         BIT_IE_LV1      = 0;
   localparam int         BIT_IE_LV2      = 1;
   localparam int         BIT_THERM_EN    = 1;
   localparam int         BIT_TRK_LO      = 4;
   localparam int         BIT_TRK_HI      = 5;
   // reset values
   localparam logic [7:0] RST_INT_CTRL    = 8'h00;
   localparam logic [7:0] RST_NV_CTRL     = 8'h00;
   localparam logic [7:0] RST_TURNOVER    = 8'h19;
   localparam logic [7:0] RST_TEMP        = 8'h00;
   localparam logic [7:0] RST_RAM         = 8'h00;
   localparam logic [7:0] TURNOVER_MASK   = 8'h3F;
   // timing
   localparam longint     CLK_HZ          = 125000000;
   localparam longint     SLOW_PERIOD_S   = 1;
   localparam longint     FAST_PERIOD_US  = 1000;
   localparam logic [26:0] SLOW_CYC = 27'(CLK_HZ * SLOW_PERIOD_S);
   localparam logic [26:0] FAST_CYC = 27'(CLK_HZ * FAST_PERIOD_US / 1000000);

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rpsm_bus_t;

   typedef enum logic [2:0] {
      ST_WAIT_XTAL = 3'b000,
      ST_FAST_SCAN = 3'b001,
      ST_CFG_LOAD  = 3'b010,
      ST_MEASURE   = 3'b011,
      ST_RUN       = 3'b100
   } rpsm_state_t;
endpackage : rpsm_pkg
`default_nettype wire

// ==== rpsm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpsm_top #(
   parameter logic [26:0] P_SLOW_CYC = rpsm_pkg::SLOW_CYC,
   parameter logic [26:0] P_FAST_CYC = rpsm_pkg::FAST_CYC
) (
   input  wire logic                i_mclk,
   input  wire logic                i_rstn,
   input  wire rpsm_pkg::rpsm_bus_t i_bus,
   output var  logic [7:0]          o_rdata,
   input  wire logic                i_xtal_ok,
   input  wire logic                i_above_lv1,
   input  wire logic                i_above_lv2,
   input  wire logic                i_backup_mode,
   input  wire logic [7:0]          i_nv_ctrl,
   input  wire logic [7:0]          i_nv_turnover,
   input  wire logic                i_temp_valid,
   input  wire logic [7:0]          i_temp_value,
   output var  logic                o_nv_read_en,
   output var  logic                o_fast_scan,
   output var  logic                o_therm_en,
   output var  logic                o_meas_req,
   output var  logic [7:0]          o_comp_temp,
   output var  logic                o_ready,
   output var  logic                o_spi_en,
   output var  logic                o_clock_out_en,
   output var  logic                o_trickle_en,
   output var  logic [1:0]          o_trickle_sel,
   output var  logic                o_int_en,
   output var  logic                o_int,
   output var  logic                o_time_suspect
);
   import rpsm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   rpsm_state_t state_reg;
   rpsm_state_t state_next;
   logic [26:0] scan_cnt_reg;
   logic [26:0] scan_cnt_next;
   logic        rst_done_reg;
   logic        pwr_on_reg;
   logic        pwr_on_next;
   logic        lv1_reg;
   logic        lv1_next;
   logic        lv2_reg;
   logic        lv2_next;
   logic [7:0]  int_ctrl_reg;
   logic [7:0]  nv_ctrl_reg;
   logic [7:0]  nv_ctrl_next;
   logic [7:0]  turnover_reg;
   logic [7:0]  turnover_next;
   logic [7:0]  temp_reg;
   logic [7:0]  ram_reg [RAM_DEPTH];
   logic        bk_meta_reg;
   logic        bk_sync_reg;
   logic        bk_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // address decode, bus is dead while on backup supply
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   wire       bus_live  = !bk_sync_reg;
   wire       wr_ok     = i_bus.wr && bus_live;
   wire       rd_ok     = i_bus.rd && bus_live;
   wire       wr_status = wr_ok && hit(i_bus.addr, ADDR_STATUS);
   wire       wr_intc   = wr_ok && hit(i_bus.addr, ADDR_INT_CTRL);
   wire       wr_nvc    = wr_ok && hit(i_bus.addr, ADDR_NV_CTRL);
   wire       wr_turn   = wr_ok && hit(i_bus.addr, ADDR_TURNOVER);
   wire       ram_sel   = (i_bus.addr >= ADDR_RAM_FIRST) &&
                          (i_bus.addr <= ADDR_RAM_LAST);
   wire [2:0] ram_idx   = i_bus.addr[2:0];
   wire       wr_ram    = wr_ok && ram_sel;

   ////////////////////////////////////////////////////////////////////////
   // scan timer, fast during power-up, slow afterwards
   wire        scanning  = (state_reg != ST_WAIT_XTAL);
   wire        fast_mode = (state_reg == ST_FAST_SCAN);
   wire [26:0] period    = fast_mode ? P_FAST_CYC : P_SLOW_CYC;
   wire        scan_tick = scanning && (scan_cnt_reg == period - 27'h1);
   wire        fast_done = fast_mode && scan_tick && i_above_lv2;
   // during fast scan only a passing sample matters, so no flag set there
   wire        slow_tick = scan_tick && !fast_mode;
   wire        set_lv1   = slow_tick && !i_above_lv1;
   wire        set_lv2   = slow_tick && !i_above_lv2;

   assign scan_cnt_next = (!scanning || scan_tick || fast_done) ? 27'h0 :
                          scan_cnt_reg + 27'h1;

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   wire therm_cfg = nv_ctrl_reg[BIT_THERM_EN];
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_WAIT_XTAL: begin
            if (i_xtal_ok) begin
               state_next = ST_FAST_SCAN;
            end
         end
         ST_FAST_SCAN: begin
            if (fast_done) begin
               state_next = ST_CFG_LOAD;
            end
         end
         ST_CFG_LOAD: begin
            // thermometer bit is tested on the freshly loaded value
            state_next = i_nv_ctrl[BIT_THERM_EN] ? ST_MEASURE : ST_RUN;
         end
         ST_MEASURE: begin
            if (i_temp_valid) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_WAIT_XTAL;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // flags: hardware set wins over a software clear in the same cycle
   wire load_cyc = (state_reg == ST_CFG_LOAD);
   assign pwr_on_next = !rst_done_reg ? 1'b1 :
                        (wr_status && !i_bus.wdata[BIT_PWR_ON]) ? 1'b0 :
                        pwr_on_reg;
   assign lv1_next = set_lv1 ? 1'b1 :
                     (load_cyc || (wr_status && !i_bus.wdata[BIT_LV1])) ?
                     1'b0 : lv1_reg;
   assign lv2_next = set_lv2 ? 1'b1 :
                     (load_cyc || (wr_status && !i_bus.wdata[BIT_LV2])) ?
                     1'b0 : lv2_reg;

   // configuration comes from the nv page, software may still rewrite it
   assign nv_ctrl_next  = load_cyc ? i_nv_ctrl :
                          wr_nvc ? i_bus.wdata : nv_ctrl_reg;
   assign turnover_next = load_cyc ? (i_nv_turnover & TURNOVER_MASK) :
                          wr_turn ? (i_bus.wdata & TURNOVER_MASK) :
                          turnover_reg;

   ////////////////////////////////////////////////////////////////////////
   // thermometer runs only with both flags clear; otherwise reading frozen
   wire lv_any       = lv1_reg || lv2_reg;
   wire therm_active = therm_cfg && !lv_any &&
                       ((state_reg == ST_MEASURE) || (state_reg == ST_RUN));
   wire temp_load    = therm_active && i_temp_valid;

   ////////////////////////////////////////////////////////////////////////
   // backup gating and trickle selection
   wire       bk_enter = bk_sync_reg && !bk_prev_reg;
   wire [1:0] trk_sel  = nv_ctrl_reg[BIT_TRK_HI:BIT_TRK_LO];
   wire       lv_irq   = (lv1_reg && int_ctrl_reg[BIT_IE_LV1]) ||
                         (lv2_reg && int_ctrl_reg[BIT_IE_LV2]);

   ////////////////////////////////////////////////////////////////////////
   // read mux, unmapped addresses read zero
   wire [7:0] status_rd = {!o_ready, 1'b0, pwr_on_reg, 1'b0, lv2_reg,
                           lv1_reg, 2'b00};
   wire [7:0] rd_mux =
      hit(i_bus.addr, ADDR_STATUS)   ? status_rd    :
      hit(i_bus.addr, ADDR_INT_CTRL) ? int_ctrl_reg :
      hit(i_bus.addr, ADDR_TEMP)     ? temp_reg     :
      hit(i_bus.addr, ADDR_NV_CTRL)  ? nv_ctrl_reg  :
      hit(i_bus.addr, ADDR_TURNOVER) ? turnover_reg :
      ram_sel                        ? ram_reg[ram_idx] : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // backup level synchroniser
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         bk_meta_reg <= 1'b0;
         bk_sync_reg <= 1'b0;
         bk_prev_reg <= 1'b0;
      end else begin
         bk_meta_reg <= i_backup_mode;
         bk_sync_reg <= bk_meta_reg;
         bk_prev_reg <= bk_sync_reg;
      end
   end

   // sequencer and flags
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg    <= ST_WAIT_XTAL;
         scan_cnt_reg <= 27'h0;
         rst_done_reg <= 1'b0;
         pwr_on_reg   <= 1'b0;
         lv1_reg      <= 1'b0;
         lv2_reg      <= 1'b0;
      end else begin
         state_reg    <= state_next;
         scan_cnt_reg <= scan_cnt_next;
         rst_done_reg <= 1'b1;
         pwr_on_reg   <= pwr_on_next;
         lv1_reg      <= lv1_next;
         lv2_reg      <= lv2_next;
      end
   end

   // configuration registers
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         int_ctrl_reg <= RST_INT_CTRL;
         nv_ctrl_reg  <= RST_NV_CTRL;
         turnover_reg <= RST_TURNOVER;
         temp_reg     <= RST_TEMP;
      end else begin
         if (wr_intc) begin
            int_ctrl_reg <= i_bus.wdata;
         end
         // backup entry wipes the resistor choice so charging stays off
         nv_ctrl_reg  <= bk_enter ?
                         (nv_ctrl_next & ~(8'h03 << BIT_TRK_LO)) : nv_ctrl_next;
         turnover_reg <= turnover_next;
         if (temp_load) begin
            temp_reg <= i_temp_value;
         end
      end
   end

   // scratch bytes
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < RAM_DEPTH; i++) begin
            ram_reg[i] <= RST_RAM;
         end
      end else if (wr_ram) begin
         ram_reg[ram_idx] <= i_bus.wdata;
      end
   end

   // registered outputs
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata        <= 8'h00;
         o_nv_read_en   <= 1'b0;
         o_fast_scan    <= 1'b0;
         o_therm_en     <= 1'b0;
         o_meas_req     <= 1'b0;
         o_comp_temp    <= RST_TEMP;
         o_ready        <= 1'b0;
         o_spi_en       <= 1'b0;
         o_clock_out_en <= 1'b0;
         o_trickle_en   <= 1'b0;
         o_trickle_sel  <= 2'b00;
         o_int_en       <= 1'b0;
         o_int          <= 1'b0;
         o_time_suspect <= 1'b0;
      end else begin
         o_rdata        <= rd_ok ? rd_mux : 8'h00;
         o_nv_read_en   <= (state_next != ST_WAIT_XTAL) &&
                           (state_next != ST_FAST_SCAN);
         o_fast_scan    <= (state_next == ST_FAST_SCAN);
         o_therm_en     <= therm_active;
         o_meas_req     <= (state_next == ST_MEASURE);
         o_comp_temp    <= temp_reg;
         o_ready        <= (state_next == ST_RUN);
         o_spi_en       <= !bk_sync_reg;
         o_clock_out_en <= !bk_sync_reg;
         o_trickle_en   <= !bk_sync_reg && (trk_sel != 2'b00);
         o_trickle_sel  <= bk_sync_reg ? 2'b00 : trk_sel;
         o_int_en       <= 1'b1;
         o_int          <= lv_irq;
         o_time_suspect <= lv2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_pass_fast;
      (state_reg == ST_FAST_SCAN) && scan_tick && i_above_lv2;
   endsequence
   sequence s_load_then_nv;
      (state_reg == ST_CFG_LOAD) && o_nv_read_en;
   endsequence

   a_pwr_on_after_reset: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      !rst_done_reg |=> pwr_on_reg)
      else $error("power-on flag not set after reset");
   a_pwr_on_held: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (pwr_on_reg && !(wr_status && !i_bus.wdata[BIT_PWR_ON])) |=> pwr_on_reg)
      else $error("power-on flag cleared without a write of 0");
   a_turnover_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      turnover_reg[7:6] == 2'b00)
      else $error("turnover upper bits not zero");
   a_ram_write_read: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      wr_ram |=> ram_reg[$past(ram_idx)] == $past(i_bus.wdata))
      else $error("scratch byte not stored");
   a_backup_gates_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      bk_sync_reg |=> (!o_spi_en && !o_clock_out_en && !o_trickle_en &&
                       o_int_en))
      else $error("function left on in backup mode");
   a_trickle_needs_sel: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      o_trickle_en |-> (o_trickle_sel != 2'b00))
      else $error("trickle on without resistor selection");
   a_fast_to_load: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      s_pass_fast |=> s_load_then_nv ##1 !o_fast_scan)
      else $error("fast scan did not hand over to config load");
   a_load_clears_flags: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (load_cyc && !slow_tick) |=> (!lv1_reg && !lv2_reg))
      else $error("low-voltage flags not cleared after load");
   a_meas_before_ready: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (load_cyc && i_nv_ctrl[BIT_THERM_EN]) |=> (state_reg == ST_MEASURE) ##1 !o_ready)
      else $error("ready without a measurement");
   a_low_sets_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      set_lv1 |=> lv1_reg ##1 !o_therm_en)
      else $error("first low-voltage flag not set");
   a_lv2_sets_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      set_lv2 |=> lv2_reg ##1 o_time_suspect)
      else $error("second low-voltage flag not reported");
   a_temp_frozen: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      lv_any |=> $stable(temp_reg))
      else $error("temperature moved while flags set");
   a_lv_irq_raise: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (set_lv1 && int_ctrl_reg[BIT_IE_LV1] && !wr_intc) |=> ##1 o_int)
      else $error("interrupt not raised on low voltage");
endmodule : rpsm_top
`default_nettype wire

// ==== rpsm_supply_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// supply comparators and thermometer on the far side of the monitor
module rpsm_supply_model (
   input  wire logic       i_mclk,
   input  wire logic [1:0] i_supply,
   input  wire logic       i_meas_req,
   input  wire logic       i_therm_en,
   input  wire logic       i_force,
   input  wire logic       i_slow,
   input  wire logic [7:0] i_value,
   output var  logic       o_above_lv1,
   output var  logic       o_above_lv2,
   output var  logic       o_temp_valid,
   output var  logic [7:0] o_temp_value
);
   int unsigned cnt  = 0;
   logic [7:0]  last = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // supply level 0 below both, 1 between, 2 above both thresholds
   assign o_above_lv1 = (i_supply == 2'd2);
   assign o_above_lv2 = (i_supply != 2'd0);
   // reading after a short or long conversion; force models a thermometer
   // that keeps reporting although the monitor has switched it off
   always @(posedge i_mclk) begin
      if ((i_meas_req | i_therm_en | i_force) &&
          (cnt >= (i_slow ? 12 : 3))) begin
         cnt          <= 0;
         o_temp_valid <= 1'b1;
         o_temp_value <= i_value;
         last         <= i_value;
      end else begin
         // no stale value between readings
         cnt          <= (i_meas_req | i_therm_en | i_force) ? cnt + 1 : 0;
         o_temp_valid <= 1'b0;
         o_temp_value <= ~last;
      end
   end
endmodule : rpsm_supply_model
`default_nettype wire

// ==== rpsm_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpsm_top_tb;
   import rpsm_pkg::*;
   logic       i_mclk = 1'b0;
   logic       i_rstn = 1'b0;
   rpsm_bus_t  bus    = '0;
   logic       xtal = 1'b0, bmode = 1'b0, frc = 1'b0, slow = 1'b1;
   logic [1:0] sup = 2'd0, tsel;
   logic [7:0] nvc = 8'h12, nvt = 8'h00, tv = 8'h00, tval = 8'h00;
   logic [7:0] rdata, ctemp, tvalue, rd_v, tv2;
   logic [7:0] ram [RAM_DEPTH];
   logic a1, a2, tvld, nvre, fast, then, mreq, rdy, spi, clko, trk, inte;
   logic irq, tsus;
   int   n_errors = 0, check_count = 0, i;
   int unsigned rnd;
   always #4 i_mclk = ~i_mclk;
   ////////////////////////////////////////////////////////////////////////
   rpsm_top #(.P_SLOW_CYC(27'd20), .P_FAST_CYC(27'd5)) i_rpsm_top (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata),
      .i_xtal_ok(xtal), .i_above_lv1(a1), .i_above_lv2(a2),
      .i_backup_mode(bmode), .i_nv_ctrl(nvc), .i_nv_turnover(nvt),
      .i_temp_valid(tvld), .i_temp_value(tvalue), .o_nv_read_en(nvre),
      .o_fast_scan(fast), .o_therm_en(then), .o_meas_req(mreq),
      .o_comp_temp(ctemp), .o_ready(rdy), .o_spi_en(spi),
      .o_clock_out_en(clko), .o_trickle_en(trk), .o_trickle_sel(tsel),
      .o_int_en(inte), .o_int(irq), .o_time_suspect(tsus));
   rpsm_supply_model i_rpsm_supply_model (
      .i_mclk(i_mclk), .i_supply(sup), .i_meas_req(mreq),
      .i_therm_en(then), .i_force(frc), .i_slow(slow), .i_value(tval),
      .o_above_lv1(a1), .o_above_lv2(a2), .o_temp_valid(tvld),
      .o_temp_value(tvalue));
   ////////////////////////////////////////////////////////////////////////
   // status byte from {busy, power-on, low2, low1}
   function automatic logic [7:0] st(input logic [3:0] f);
      return {f[3], 1'b0, f[2], 1'b0, f[1], f[0], 2'b00};
   endfunction : st
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one strobe cycle, then idle; read data land after the sampling edge
   task automatic bus_op(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge i_mclk);
      bus <= {a, d, w, !w};
      @(posedge i_mclk);
      bus <= '0;
      #1 rd_v = rdata;
   endtask : bus_op
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus_op(1'b0, a, 8'h00);
      chk(rd_v, exp);
   endtask : rd
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      repeat (6000) @(posedge i_mclk);
      n_errors++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rnd  = $urandom(32'h143A);
      tv   = 8'($urandom());
      nvt  <= 8'(rnd);
      tval <= tv;
      // registers only settle at the first edge under reset
      @(posedge i_mclk);
      #1 chk(rdata, 8'h00);
      chk(8'({nvre, fast, rdy, spi}), 8'h00);
      repeat (2) @(posedge i_mclk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(ADDR_STATUS, st(4'b1100));
      rd(ADDR_TURNOVER, RST_TURNOVER);
      for (i = 0; i < RAM_DEPTH; i++)
         rd(ADDR_RAM_FIRST + 8'(i), RST_RAM);
      chk(8'({spi, clko, inte, fast, nvre}), 8'h1C);
      // fast scan with the supply still low: no config load yet
      @(posedge i_mclk);
      xtal <= 1'b1;
      repeat (18) @(posedge i_mclk);
      #1 chk(8'({fast, nvre}), 8'h02);
      rd(ADDR_STATUS, st(4'b1100));
      @(posedge i_mclk);
      sup <= 2'd2;
      for (i = 0; i < 20 && nvre !== 1'b1; i++) @(posedge i_mclk) #1;
      chk(8'({nvre, fast}), 8'h02);
      @(posedge i_mclk) #1;
      chk(8'({mreq, rdy}), 8'h02);
      rd(ADDR_TURNOVER, nvt & TURNOVER_MASK);
      rd(ADDR_NV_CTRL, nvc);
      rd(ADDR_STATUS, st(4'b1100));
      for (i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge i_mclk) #1;
      chk(8'({rdy, mreq}), 8'h02);
      rd(ADDR_TEMP, tv);
      // power-on flag: a one is ignored, a zero clears
      bus_op(1'b1, ADDR_STATUS, 8'hFF);
      rd(ADDR_STATUS, st(4'b0100));
      bus_op(1'b1, ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, st(4'b0000));
      // scratch bytes with all-ones and all-zeros at the ends
      for (i = 0; i < RAM_DEPTH; i++) begin
         ram[i] = (i == 0) ? 8'hFF : (i == 7) ? 8'h00 : 8'($urandom());
         bus_op(1'b1, ADDR_RAM_FIRST + 8'(i), ram[i]);
      end
      for (i = 0; i < RAM_DEPTH; i++)
         rd(ADDR_RAM_FIRST + 8'(i), ram[i]);
      tv2 = 8'($urandom()) | 8'hC0;
      bus_op(1'b1, ADDR_TURNOVER, tv2);
      rd(ADDR_TURNOVER, tv2 & TURNOVER_MASK);
      bus_op(1'b1, ADDR_TEMP, ~tv);
      rd(ADDR_TEMP, tv);
      rd(8'h40, 8'h00);
      // trickle follows the resistor selection
      chk(8'({trk, tsel}), 8'h05);
      bus_op(1'b1, ADDR_NV_CTRL, 8'h02);
      @(posedge i_mclk) #1;
      chk(8'({trk, tsel}), 8'h00);
      bus_op(1'b1, ADDR_NV_CTRL, 8'h22);
      @(posedge i_mclk) #1;
      chk(8'({trk, tsel}), 8'h06);
      // backup supply: host side shut, interrupt kept, selection dropped
      @(posedge i_mclk);
      bmode <= 1'b1;
      repeat (4) @(posedge i_mclk);
      #1 chk(8'({spi, clko, trk, inte}), 8'h01);
      rd(ADDR_RAM_FIRST, 8'h00);
      @(posedge i_mclk);
      bmode <= 1'b0;
      repeat (4) @(posedge i_mclk);
      #1 chk(8'({spi, clko, trk, inte}), 8'h0D);
      rd(ADDR_NV_CTRL, 8'h02);
      // supply sags below the first, then the second threshold
      bus_op(1'b1, ADDR_INT_CTRL, 8'h01);
      @(posedge i_mclk);
      slow <= 1'b0;
      sup  <= 2'd1;
      for (i = 0; i < 30 && irq !== 1'b1; i++) @(posedge i_mclk) #1;
      chk(8'({irq, then, tsus}), 8'h04);
      rd(ADDR_STATUS, st(4'b0001));
      @(posedge i_mclk);
      tval <= ~tv;
      frc  <= 1'b1;
      repeat (12) @(posedge i_mclk);
      rd(ADDR_TEMP, tv);
      chk(ctemp, tv);
      @(posedge i_mclk);
      sup <= 2'd0;
      for (i = 0; i < 30 && tsus !== 1'b1; i++) @(posedge i_mclk) #1;
      chk(8'({tsus, irq}), 8'h03);
      rd(ADDR_STATUS, st(4'b0011));
      bus_op(1'b1, ADDR_INT_CTRL, 8'h02);
      @(posedge i_mclk) #1;
      chk(8'(irq), 8'h01);
      bus_op(1'b1, ADDR_INT_CTRL, 8'h00);
      @(posedge i_mclk) #1;
      chk(8'(irq), 8'h00);
      // supply back: flags stay and the reading stays frozen until cleared
      @(posedge i_mclk);
      sup <= 2'd2;
      frc <= 1'b0;
      repeat (25) @(posedge i_mclk);
      rd(ADDR_STATUS, st(4'b0011));
      rd(ADDR_TEMP, tv);
      bus_op(1'b1, ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, st(4'b0000));
      for (i = 0; i < 40 && ctemp !== ~tv; i++) @(posedge i_mclk) #1;
      chk(ctemp, ~tv);
      rd(ADDR_TEMP, ~tv);
      // second power-up reset in mid-run
      @(posedge i_mclk);
      i_rstn <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(ADDR_STATUS, st(4'b1100));
      rd(ADDR_RAM_FIRST, RST_RAM);
      end_sim();
   end
endmodule : rpsm_top_tb
`default_nettype wire
